/* verilog/e1sa_regs.svh */
// Register map, field positions, reset values and bus codes for the
// receive spare-bit capture block. Definitions only.
// Assumes an AXI4-Lite slave with 32-bit data, one register per word.
//
// Behaviour
// RQ1: Separate eight-bit read-only register per spare position
// RQ2: Register holds latest complete multiframe's bits
// RQ3: Load only after whole multiframe received
// RQ4: Capture only while position's receive select is set
// RQ5: Bit 7 frame 2, bit 6 frame 4
// RQ6: Bits 5..0 from frames 6 to 16
`ifndef E1SA_REGS_SVH
`define E1SA_REGS_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define E1SA_IDX_CTRL 10'h10c
`define E1SA_IDX_SPARE6 10'h13d
`define E1SA_IDX_SPARE7 10'h13e
`define E1SA_IDX_SPARE8 10'h13f

// ==========================================================
// Receive select bits in the control register, and reset values
`define E1SA_SEL6_BIT 0
`define E1SA_SEL7_BIT 1
`define E1SA_SEL8_BIT 2
`define E1SA_CTRL_RESET 3'h0
`define E1SA_CAPTURE_RESET 8'h00

// ==========================================================
// Multiframe numbering: index 0..15 stands for frames 1..16
`define E1SA_FIRST_FRAME 4'h0
`define E1SA_LAST_FRAME 4'hf

// ==========================================================
// AXI response codes
`define E1SA_RESP_OKAY 2'h0
`define E1SA_RESP_SLVERR 2'h2

`endif

/* verilog/e1sa_pkg.sv */
// Shared types for the receive spare-bit capture block.
// Assumes the constants header is included by the design file.
package e1sa_pkg;
  // One captured byte of spare bits
  typedef logic [7:0] e1sa_byte_t;
  // AXI response code
  typedef logic [1:0] e1sa_resp_t;
  // Register word index
  typedef logic [9:0] e1sa_index_t;
endpackage : e1sa_pkg

/* verilog/e1sa_capture.sv */
// Receive capture of the Sa6, Sa7 and Sa8 national spare bits.
// Assumes the frame strobe, index and spare bits come from the receive
// framer on aclk, already aligned to the CRC-4 multiframe.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "e1sa_regs.svh"

module e1sa_capture #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Receive framer side
  input wire logic rx_frame_valid,
  input wire logic [3:0] rx_frame_index,
  input wire logic rx_mf_locked,
  input wire logic received_spare6_bits,
  input wire logic received_spare7_bits,
  input wire logic received_spare8_bits,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ==========================================================
  // Helpers
  // Word index of a byte address
  function automatic e1sa_pkg::e1sa_index_t word_index(
    input logic [ADDR_W-1:0] addr);
    word_index = e1sa_pkg::e1sa_index_t'(addr[ADDR_W-1:2]);
  endfunction : word_index

  // Byte bit position for an even frame (index odd): frame 2 -> bit 7
  function automatic logic [2:0] spare_pos(input logic [3:0] idx);
    spare_pos = 3'h7 - idx[3:1];
  endfunction : spare_pos

  // ==========================================================
  // State
  logic [2:0] spare_select; // Receive select bits, software written
  logic [3:0] expect_index; // Next frame index expected
  logic collecting; // Current multiframe seen in order so far
  e1sa_pkg::e1sa_byte_t shadow6; // Partial bytes, never visible
  e1sa_pkg::e1sa_byte_t shadow7;
  e1sa_pkg::e1sa_byte_t shadow8;
  e1sa_pkg::e1sa_byte_t rx_spare_bit6_capture; // Visible registers
  e1sa_pkg::e1sa_byte_t rx_spare_bit7_capture;
  e1sa_pkg::e1sa_byte_t rx_spare_bit8_capture;
  logic in_order; // Frame arrives where expected
  logic mf_done; // Last frame of a clean multiframe
  logic [2:0] pos; // Bit slot of this frame
  logic aw_held, w_held; // Write halves taken, awaiting the other
  e1sa_pkg::e1sa_index_t aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  e1sa_pkg::e1sa_index_t ar_index;

  assign in_order = rx_frame_valid && rx_mf_locked &&
                    (rx_frame_index == expect_index);
  assign mf_done = in_order && collecting &&
                   (rx_frame_index == `E1SA_LAST_FRAME);
  assign pos = spare_pos(rx_frame_index);

  // ==========================================================
  // Multiframe tracking
  // Any skipped frame or loss of lock discards the multiframe, so a
  // register never takes bits from two different multiframes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expect_index <= `E1SA_FIRST_FRAME;
      collecting <= 1'b0;
    end else if (!rx_mf_locked) begin
      expect_index <= `E1SA_FIRST_FRAME;
      collecting <= 1'b0;
    end else if (rx_frame_valid) begin
      expect_index <= rx_frame_index + 4'h1;
      // Start fresh on frame 1, stay clean only while in order
      if (rx_frame_index == `E1SA_FIRST_FRAME) begin
        collecting <= 1'b1; // RQ3
      end else begin
        collecting <= collecting && in_order; // RQ3
      end
    end
  end

  // ==========================================================
  // Shadow collection on even-numbered frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow6 <= `E1SA_CAPTURE_RESET;
      shadow7 <= `E1SA_CAPTURE_RESET;
      shadow8 <= `E1SA_CAPTURE_RESET;
    end else if (rx_frame_valid && rx_frame_index[0]) begin
      shadow6[pos] <= received_spare6_bits; // RQ5 RQ6
      shadow7[pos] <= received_spare7_bits; // RQ5 RQ6
      shadow8[pos] <= received_spare8_bits; // RQ5 RQ6
    end
  end

  // ==========================================================
  // Visible capture registers, loaded on frame 16 of a clean multiframe
  // Frame 16 supplies bit 0 directly, so the load needs no extra cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_spare_bit6_capture <= `E1SA_CAPTURE_RESET;
      rx_spare_bit7_capture <= `E1SA_CAPTURE_RESET;
      rx_spare_bit8_capture <= `E1SA_CAPTURE_RESET;
    end else if (mf_done) begin
      // Disabled positions keep their last value
      if (spare_select[`E1SA_SEL6_BIT]) begin // RQ4
        rx_spare_bit6_capture <= {shadow6[7:1], received_spare6_bits}; // RQ2
      end
      if (spare_select[`E1SA_SEL7_BIT]) begin // RQ4
        rx_spare_bit7_capture <= {shadow7[7:1], received_spare7_bits}; // RQ2
      end
      if (spare_select[`E1SA_SEL8_BIT]) begin // RQ4
        rx_spare_bit8_capture <= {shadow8[7:1], received_spare8_bits}; // RQ2
      end
    end
  end

  // ==========================================================
  // AXI write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 10'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (aw_held && w_held) begin
      // Both halves consumed by the response stage
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_index <= word_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Control register write and write response
  // Capture registers are read-only: writes there are ignored with OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spare_select <= `E1SA_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `E1SA_RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `E1SA_RESP_OKAY;
      case (aw_index)
        `E1SA_IDX_CTRL: begin
          if (w_strb[0]) begin
            spare_select <= w_data[2:0]; // RQ4
          end
        end
        `E1SA_IDX_SPARE6, `E1SA_IDX_SPARE7, `E1SA_IDX_SPARE8: begin
          s_axi_bresp <= `E1SA_RESP_OKAY; // RQ1
        end
        default: begin
          s_axi_bresp <= `E1SA_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI read path: one read at a time, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_index = word_index(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `E1SA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `E1SA_RESP_OKAY;
      case (ar_index)
        `E1SA_IDX_CTRL: begin
          s_axi_rdata <= {29'h0, spare_select};
        end
        `E1SA_IDX_SPARE6: begin
          s_axi_rdata <= {24'h0, rx_spare_bit6_capture}; // RQ1
        end
        `E1SA_IDX_SPARE7: begin
          s_axi_rdata <= {24'h0, rx_spare_bit7_capture}; // RQ1
        end
        `E1SA_IDX_SPARE8: begin
          s_axi_rdata <= {24'h0, rx_spare_bit8_capture}; // RQ1
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `E1SA_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  AST_READ_SPARE7: assert property (@(posedge aclk) // RQ1
    disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ar_index == `E1SA_IDX_SPARE7
    |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(rx_spare_bit7_capture)})
    else $error("Spare7 read data mismatch");

  AST_LOAD_VALUE: assert property (@(posedge aclk) // RQ2
    disable iff (!aresetn)
    mf_done && spare_select[`E1SA_SEL6_BIT]
    |=> rx_spare_bit6_capture ==
        {$past(shadow6[7:1]), $past(received_spare6_bits)})
    else $error("Spare6 capture not loaded from multiframe");

  AST_LOAD_AT_END: assert property (@(posedge aclk) // RQ3
    disable iff (!aresetn)
    !$stable(rx_spare_bit8_capture) |-> $past(mf_done))
    else $error("Spare8 capture changed mid multiframe");

  AST_HOLD_DISABLED: assert property (@(posedge aclk) // RQ4
    disable iff (!aresetn)
    !spare_select[`E1SA_SEL7_BIT] ##1 !spare_select[`E1SA_SEL7_BIT]
    |-> $stable(rx_spare_bit7_capture))
    else $error("Spare7 capture moved while deselected");

  AST_FRAME2_BIT7: assert property (@(posedge aclk) // RQ5
    disable iff (!aresetn)
    rx_frame_valid && rx_frame_index == 4'h1
    |=> shadow6[7] == $past(received_spare6_bits))
    else $error("Frame 2 bit not in bit 7");

  AST_FRAME14_BIT1: assert property (@(posedge aclk) // RQ6
    disable iff (!aresetn)
    rx_frame_valid && rx_frame_index == 4'hd
    |=> shadow8[1] == $past(received_spare8_bits))
    else $error("Frame 14 bit not in bit 1");

endmodule : e1sa_capture

/* dv/e1sa_far_end.sv */
// Far-end model: remote terminal sending CRC-4 multiframes.
// Assumes a start pulse on aclk; one frame every four cycles.
`timescale 1ns/1ps

module e1sa_far_end (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic start,
  input wire logic [1:0] fault_mode,
  input wire logic [7:0] byte6,
  input wire logic [7:0] byte7,
  input wire logic [7:0] byte8,
  output logic busy,
  // Framer lines
  output logic rx_frame_valid,
  output logic [3:0] rx_frame_index,
  output logic rx_mf_locked,
  output logic received_spare6_bits,
  output logic received_spare7_bits,
  output logic received_spare8_bits
);
  // ==========================================================
  // Sequencing
  logic [5:0] cnt; // Phase in [1:0], frame in [5:2]
  logic [1:0] mode; // 1 index jump, 2 lock loss
  logic [7:0] b6, b7, b8; // Latched bytes
  logic [2:0] pos, sel, sa_now, sa_last; // Bit slot, picked bits, line values now and last
  // One multiframe per start pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      mode <= 2'h0;
      {b6, b7, b8} <= 24'h000000;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= 6'h00;
      mode <= fault_mode;
      {b6, b7, b8} <= {byte6, byte7, byte8};
    end else if (busy) begin
      cnt <= cnt + 6'h01;
      busy <= (cnt != 6'h3f);
    end
  end
  // Faults damage frame 6 index or frame 9 lock
  always_comb begin
    rx_frame_valid = busy && (cnt[1:0] == 2'h0);
    rx_frame_index = (mode == 2'h1 && cnt[5:2] == 4'h5) ? 4'h7 : cnt[5:2];
    rx_mf_locked = !(mode == 2'h2 && cnt[5:2] == 4'h8);
    pos = 3'h7 - rx_frame_index[3:1];
    sel = {b8[pos], b7[pos], b6[pos]};
    // Odd frames carry the inverse so that a wrong pick shows
    if (!rx_frame_valid) sa_now = ~sa_last;
    else if (rx_frame_index[0]) sa_now = sel;
    else sa_now = ~sel;
  end
  // Idle lines show the inverse of the last bit, not a held value
  always_ff @(posedge aclk) begin
    if (!aresetn) sa_last <= 3'h0;
    else if (rx_frame_valid) sa_last <= sa_now;
  end
  assign {received_spare8_bits, received_spare7_bits} = sa_now[2:1];
  assign received_spare6_bits = sa_now[0];
endmodule : e1sa_far_end

/* dv/test_e1_rx_sa_bit_capture.sv */
// Self-checking bench for the spare-bit capture block.
// Assumes the far-end model drives all framer inputs.
`timescale 1ns/1ps
`include "e1sa_regs.svh"
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %0t: got %h want %h", $time, (got), (exp)); \
    end \
  end

module test_e1_rx_sa_bit_capture;
  // ==========================================================
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0;
  logic [1:0] fault = 2'h0, resp;
  logic [7:0] v6 = 8'h00, v7 = 8'h00, v8 = 8'h00;
  logic busy, fv, lk, s6, s7, s8;
  logic [3:0] fi;
  logic awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, awr, wr, arr;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp;
  int fail_count = 0, n_tests = 0;
  localparam logic [11:0] A6 = {`E1SA_IDX_SPARE6, 2'b00};
  localparam logic [11:0] A7 = {`E1SA_IDX_SPARE7, 2'b00};
  localparam logic [11:0] A8 = {`E1SA_IDX_SPARE8, 2'b00};
  localparam logic [11:0] AC = {`E1SA_IDX_CTRL, 2'b00};
  localparam logic [1:0] OK = `E1SA_RESP_OKAY;
  always #50 aclk = ~aclk; // 10 MHz

  e1sa_far_end u_far (.aclk(aclk), .aresetn(aresetn), .start(start),
    .fault_mode(fault), .byte6(v6), .byte7(v7), .byte8(v8), .busy(busy),
    .rx_frame_valid(fv), .rx_frame_index(fi), .rx_mf_locked(lk),
    .received_spare6_bits(s6), .received_spare7_bits(s7),
    .received_spare8_bits(s8));
  e1sa_capture u_dut (.aclk(aclk), .aresetn(aresetn), .rx_frame_valid(fv),
    .rx_frame_index(fi), .rx_mf_locked(lk), .received_spare6_bits(s6),
    .received_spare7_bits(s7), .received_spare8_bits(s8),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp));

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // A used-up bound counts as a mismatch and ends the run
  task automatic bound(input int n);
    if (n >= 200) begin
      fail_count++;
      report_and_stop();
    end
  endtask : bound
  // Write; each half is released when taken
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {awv, wv, br, awa, wd} <= {3'b111, a, d};
    n = 0;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 200);
    bound(n);
    resp = bresp;
    br <= 1'b0;
  endtask : wr_reg
  // Read and compare data and response
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    {arv, rr, ara} <= {2'b11, a};
    n = 0;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 200);
    bound(n);
    `CHK({rd, rresp}, {24'h0, e, er})
    rr <= 1'b0;
  endtask : rd_chk
  // Start a multiframe; wait for the far end when asked
  task automatic mf(input logic [1:0] f, input logic [23:0] v, input bit w);
    int n;
    @(posedge aclk);
    {fault, v6, v7, v8, start} <= {f, v, 1'b1};
    @(posedge aclk);
    start <= 1'b0;
    // Busy is only seen high one edge after the start pulse is taken
    @(posedge aclk);
    for (n = 0; w && busy !== 1'b0 && n < 200; n++) @(posedge aclk);
    bound(n);
  endtask : mf
  // Compare all three captures
  task automatic all3(input logic [23:0] e);
    rd_chk(A6, e[23:16], OK);
    rd_chk(A7, e[15:8], OK);
    rd_chk(A8, e[7:0], OK);
  endtask : all3

  // ==========================================================
  // Scenarios
  task automatic t_reset_map();
    all3(24'h0);
    rd_chk(AC, 8'h00, OK);
    wr_reg(A6, 32'hffff_ffff);
    `CHK(resp, OK)
    rd_chk(A6, 8'h00, OK);
    rd_chk(12'h000, 8'h00, `E1SA_RESP_SLVERR);
    wr_reg(12'h000, 32'h0000_0000);
    `CHK(resp, `E1SA_RESP_SLVERR)
  endtask : t_reset_map
  // Frame 2 lands in bit 7, frame 16 in bit 0; partial never shows
  task automatic t_order_partial();
    wr_reg(AC, 32'h7);
    mf(2'h0, 24'hc13a0f, 1);
    all3(24'hc13a0f);
    mf(2'h0, 24'h556677, 0);
    repeat (30) @(posedge aclk);
    rd_chk(A6, 8'hc1, OK);
    mf(2'h0, 24'h556677, 1);
    all3(24'h556677);
  endtask : t_order_partial
  // Broken multiframes load nothing; the next clean one does
  task automatic t_faults();
    mf(2'h1, 24'h000000, 1);
    all3(24'h556677);
    mf(2'h2, 24'h000000, 1);
    all3(24'h556677);
    mf(2'h0, 24'h123456, 1);
    all3(24'h123456);
  endtask : t_faults
  // Deselected positions keep their old bytes
  task automatic t_select();
    wr_reg(AC, 32'h5);
    mf(2'h0, 24'h9abcde, 1);
    all3(24'h9a34de);
    wr_reg(AC, 32'h0);
    mf(2'h0, 24'hffffff, 1);
    all3(24'h9a34de);
  endtask : t_select

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_order_partial();
    t_faults();
    t_select();
    report_and_stop();
  end
endmodule : test_e1_rx_sa_bit_capture
